// >>> logic/pqc_glitch_filter.sv
// pqc_glitch_filter: three-flop sampler with low-pulse rejection
// assumes an asynchronous input level, idle high
`timescale 1ns/1ps
module pqc_glitch_filter
  import pqc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic din,
  output logic dout
);
  logic s1;
  logic s2;
  logic s3;
  logic [7:0] cnt;
  wire agree = (s2 == s3);
  wire differ = agree && (s3 != dout);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end
    else
    begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end
  // a new level must persist one glitch width
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt <= 8'h00;
      dout <= 1'b1;
    end
    else if (!differ)
      cnt <= 8'h00;
    else if (cnt >= 8'(GLITCH_CYC - 1))
    begin
      cnt <= 8'h00;
      dout <= s3;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule : pqc_glitch_filter

// >>> logic/pqc_pkg.sv
// pqc_pkg: constants for the quad port control pin logic
// assumes a 20 MHz system clock and an I2C master on the far side
package pqc_pkg;
  localparam int NPORT = 4;
  localparam real CLK_NS = 50.0;
  localparam real GLITCH_NS = 1000.0;
  localparam int GLITCH_CYC = ((GLITCH_NS + CLK_NS - 1.0) / CLK_NS) > 1.0 ?
    int'((GLITCH_NS + CLK_NS - 1.0) / CLK_NS) : 1;
  localparam logic [7:0] REG_INT_MASK = 8'h01;
  localparam logic [7:0] REG_PIN_STATUS = 8'h11;
  localparam logic [7:0] REG_PORT_RESET_PUSHBUTTON = 8'h1a;
  localparam logic [7:0] REG_FAULT_EVENT = 8'h06;
  localparam logic [7:0] REG_START_EVENT = 8'h08;
  localparam logic [7:0] REG_POWER_EVENT = 8'h02;
  localparam logic [2:0] SLAVE_ADDR_HI = 3'h2;
  localparam logic [7:0] MASK_RST_LOW = 8'h80;
  localparam logic [7:0] MASK_RST_HIGH = 8'he4;
  localparam int PB_INT_CLR_LO = 6;
  localparam int PB_INT_CLR_HI = 7;
  localparam int PIN_AUTO_BIT = 0;
  localparam int EV_START = 6;
  localparam int EV_ICUT = 5;
  localparam int EV_PGOOD = 1;
  localparam logic [15:0] FAULT_TIME_CYC = 16'h0800;
  localparam logic [15:0] START_TIME_CYC = 16'h0800;
endpackage : pqc_pkg

// >>> logic/pqc_port.sv
// pqc_port: per-port switch control, fault timer and event capture
// assumes comparator inputs already synchronised
`timescale 1ns/1ps
module pqc_port
  import pqc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic shut,
  input wire logic enable,
  input wire logic over_cut,
  input wire logic out_low,
  input wire logic ac_en,
  input wire logic osc,
  output logic gate_on,
  output logic pgood,
  output logic icut_ev,
  output logic start_ev,
  output logic sense_drive
);
  logic [15:0] timer;
  logic started;
  wire expire = timer >= (started ? FAULT_TIME_CYC : START_TIME_CYC);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gate_on <= 1'b0;
      timer <= 16'h0000;
      started <= 1'b0;
      icut_ev <= 1'b0;
      start_ev <= 1'b0;
      pgood <= 1'b0;
    end
    else
    begin
      icut_ev <= 1'b0;
      start_ev <= 1'b0;
      pgood <= gate_on && out_low;
      if (shut || !enable)
      begin
        gate_on <= 1'b0;
        timer <= 16'h0000;
        started <= 1'b0;
      end
      else if (gate_on && expire)
      begin
        gate_on <= 1'b0;
        icut_ev <= started;
        start_ev <= !started;
        timer <= 16'h0000;
        started <= 1'b0;
      end
      else
      begin
        gate_on <= 1'b1;
        if (gate_on && over_cut)
          timer <= timer + 16'h0001;
        else if (gate_on)
        begin
          timer <= 16'h0000;
          started <= 1'b1;
        end
      end
    end
  end
  assign sense_drive = gate_on && ac_en && osc;
endmodule : pqc_port

// >>> logic/pqc_top.sv
// pqc_top: pin-level control of a four-port power sourcing controller
// assumes an I2C master on SCL/serial_data_in, board ties the data pins
// Summary of operation
// - reset low holds all ports off and registers at power-up values
// - reset low pulses shorter than 1 us are ignored
// - interrupt pin pulls low on any enabled event
// - writing one to bit 6 or 7 of 1Ah releases interrupt
// - interrupt mask at 01h enables each event source where its bit is set
// - interrupt pin changes only between bus transactions
// - slave address is 010 followed by four select pins
// - data received on separate input, sent on open-drain output
// - low shutdown input turns that port off regardless of registers
// - shutdown input and port reset bit in 1Ah share one port-off path; the bit pulses it for one cycle only
// - shutdown low pulses shorter than 1 us are ignored
// - reset loads register values chosen by auto-mode level
// - auto-initialised bits stay writable over the bus
// - live auto-mode level reads at bit 0 of 11h
// - auto mode powers a device without any bus traffic
// - port fault timer counts while current exceeds threshold
// - timer expiry turns port off and records fault kind
// - power good set when port output voltage is low
// - oscillator drives sense pin only while powered and enabled
`timescale 1ns/1ps
module pqc_top
  import pqc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic SCL,
  input wire logic SERIAL_DATA_IN_PIN,
  output logic SERIAL_DATA_OUT_PIN_OE,
  output logic INT_OE,
  input wire logic [3:0] SLAVE_ADDRESS_SELECT_PIN,
  input wire logic [3:0] PORT_SHUTDOWN_N,
  input wire logic AUTO_MODE,
  input wire logic [3:0] OVERCURRENT_THRESHOLD,
  input wire logic [3:0] PORT_VOLTAGE_MONITOR,
  input wire logic [3:0] AC_DISCONNECT_ENABLE,
  input wire logic OSCILLATOR_INPUT,
  input wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
  output logic [3:0] SWITCH_GATE_DRIVE,
  output logic [3:0] PORT_SENSE_PIN
);
  typedef enum {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK, ST_WDATA, ST_WACK,
    ST_RDATA, ST_RACK} pqc_state_t;
  // ------------------------------------------------------------
  // reset filtering and input sampling
  // ------------------------------------------------------------
  logic rst_f;
  logic core_rst_b;
  logic supply_undervoltage_lockout_s1;
  logic supply_undervoltage_lockout_s2;
  logic supply_undervoltage_lockout_s3;
  logic auto_s1;
  logic auto_s2;
  logic auto_s3;
  logic auto_lvl;
  logic [2:0] scl_s;
  logic [2:0] sda_s;
  logic scl_q;
  logic sda_q;
  logic [3:0] oc_s1;
  logic [3:0] oc_s2;
  logic [3:0] oc_s3;
  logic [3:0] ol_s1;
  logic [3:0] ol_s2;
  logic [3:0] ol_s3;
  logic [3:0] shut_f;
  // supply lockout clears the reset filter itself
  pqc_glitch_filter u_rst_flt (
    .clk(MCLK),
    .rst_b(!SUPPLY_UNDERVOLTAGE_LOCKOUT),
    .din(RST_B),
    .dout(rst_f)
  );
  assign core_rst_b = rst_f;
  always_ff @(posedge MCLK or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      supply_undervoltage_lockout_s1 <= 1'b0;
      supply_undervoltage_lockout_s2 <= 1'b0;
      supply_undervoltage_lockout_s3 <= 1'b0;
      auto_s1 <= 1'b0;
      auto_s2 <= 1'b0;
      auto_s3 <= 1'b0;
      oc_s1 <= 4'h0;
      oc_s2 <= 4'h0;
      oc_s3 <= 4'h0;
      ol_s1 <= 4'h0;
      ol_s2 <= 4'h0;
      ol_s3 <= 4'h0;
    end
    else
    begin
      scl_s <= {scl_s[1:0], SCL};
      sda_s <= {sda_s[1:0], SERIAL_DATA_IN_PIN};
      supply_undervoltage_lockout_s1 <= SUPPLY_UNDERVOLTAGE_LOCKOUT;
      supply_undervoltage_lockout_s2 <= supply_undervoltage_lockout_s1;
      supply_undervoltage_lockout_s3 <= supply_undervoltage_lockout_s2;
      auto_s1 <= AUTO_MODE;
      auto_s2 <= auto_s1;
      auto_s3 <= auto_s2;
      oc_s1 <= OVERCURRENT_THRESHOLD;
      oc_s2 <= oc_s1;
      oc_s3 <= oc_s2;
      ol_s1 <= PORT_VOLTAGE_MONITOR;
      ol_s2 <= ol_s1;
      ol_s3 <= ol_s2;
    end
  end
  // accepted levels once second and third flop agree
  always_ff @(posedge MCLK or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      auto_lvl <= 1'b0;
    end
    else
    begin
      if (scl_s[1] == scl_s[2])
        scl_q <= scl_s[2];
      if (sda_s[1] == sda_s[2])
        sda_q <= sda_s[2];
      if (auto_s2 == auto_s3)
        auto_lvl <= auto_s3;
    end
  end
  // ------------------------------------------------------------
  // register initialisation from auto level
  // ------------------------------------------------------------
  logic init_pend;
  logic [1:0] init_cnt;
  logic supply_undervoltage_lockout_q;
  wire supply_undervoltage_lockout_exit = supply_undervoltage_lockout_q && !supply_undervoltage_lockout_s3;
  wire load_init = init_pend || supply_undervoltage_lockout_exit;
  always_ff @(posedge MCLK or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      init_pend <= 1'b1;
      init_cnt <= 2'h0;
      supply_undervoltage_lockout_q <= 1'b0;
    end
    else
    begin
      supply_undervoltage_lockout_q <= supply_undervoltage_lockout_s3;
      // hold until the auto sampler is refilled after reset
      init_cnt <= init_cnt + {1'b0, ~&init_cnt};
      if (&init_cnt && (auto_s2 == auto_s3))
        init_pend <= 1'b0;
    end
  end
  // ------------------------------------------------------------
  // serial slave
  // ------------------------------------------------------------
  pqc_state_t state;
  logic [3:0] bitc;
  logic [7:0] shreg;
  logic [7:0] reg_ptr;
  logic rd_mode;
  logic sda_drive;
  logic scl_d;
  logic sda_d;
  logic busy;
  logic [7:0] int_mask;
  logic [7:0] rd_data;
  logic [3:0] pb_port;
  logic pb_int_clr;
  logic [3:0] port_en;
  logic [3:0] icut_lat;
  logic [3:0] start_lat;
  logic [3:0] pg_lat;
  wire scl_rise = scl_q && !scl_d;
  wire scl_fall = !scl_q && scl_d;
  wire start_c = scl_q && scl_d && sda_d && !sda_q;
  wire stop_c = scl_q && scl_d && !sda_d && sda_q;
  wire addr_hit = shreg[7:1] == {SLAVE_ADDR_HI, SLAVE_ADDRESS_SELECT_PIN};
  wire wr_strobe = scl_fall && (state == ST_WACK);
  wire [7:0] pin_status = {7'h00, auto_lvl};
  wire [7:0] fault_ev = {4'h0, icut_lat};
  wire [7:0] start_ev_r = {4'h0, start_lat};
  wire [7:0] power_ev = {pg_lat, port_en};
  assign rd_data = (reg_ptr == REG_INT_MASK) ? int_mask :
    (reg_ptr == REG_PIN_STATUS) ? pin_status :
    (reg_ptr == REG_FAULT_EVENT) ? fault_ev :
    (reg_ptr == REG_START_EVENT) ? start_ev_r :
    (reg_ptr == REG_POWER_EVENT) ? power_ev : 8'h00;
  always_ff @(posedge MCLK or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      busy <= 1'b0;
    end
    else
    begin
      scl_d <= scl_q;
      sda_d <= sda_q;
      if (start_c)
        busy <= 1'b1;
      else if (stop_c)
        busy <= 1'b0;
    end
  end
  always_ff @(posedge MCLK or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      state <= ST_IDLE;
      bitc <= 4'h0;
      shreg <= 8'h00;
      reg_ptr <= 8'h00;
      rd_mode <= 1'b0;
      sda_drive <= 1'b0;
    end
    else if (start_c)
    begin
      state <= ST_ADDR;
      bitc <= 4'h0;
      sda_drive <= 1'b0;
    end
    else if (stop_c)
    begin
      state <= ST_IDLE;
      sda_drive <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (state == ST_ADDR || state == ST_REG || state == ST_WDATA)
      begin
        shreg <= {shreg[6:0], sda_q};
        bitc <= bitc + 4'h1;
      end
      else if (state == ST_RACK && sda_q)
        state <= ST_IDLE;
    end
    else if (scl_fall)
    begin
      case (state)
        ST_ADDR:
          if (bitc == 4'h8)
          begin
            if (addr_hit)
            begin
              state <= ST_ADDR_ACK;
              rd_mode <= shreg[0];
              sda_drive <= 1'b1;
            end
            else
              state <= ST_IDLE;
          end
        ST_ADDR_ACK:
        begin
          bitc <= 4'h0;
          if (rd_mode)
          begin
            state <= ST_RDATA;
            shreg <= rd_data;
            sda_drive <= !rd_data[7];
          end
          else
          begin
            state <= ST_REG;
            sda_drive <= 1'b0;
          end
        end
        ST_REG:
          if (bitc == 4'h8)
          begin
            reg_ptr <= shreg;
            state <= ST_REG_ACK;
            sda_drive <= 1'b1;
          end
        ST_REG_ACK, ST_WACK:
        begin
          bitc <= 4'h0;
          state <= ST_WDATA;
          sda_drive <= 1'b0;
        end
        ST_WDATA:
          if (bitc == 4'h8)
          begin
            state <= ST_WACK;
            sda_drive <= 1'b1;
          end
        ST_RDATA:
          if (bitc == 4'h7)
          begin
            state <= ST_RACK;
            sda_drive <= 1'b0;
          end
          else
          begin
            bitc <= bitc + 4'h1;
            shreg <= {shreg[6:0], 1'b0};
            sda_drive <= !shreg[6];
          end
        ST_RACK:
        begin
          bitc <= 4'h0;
          state <= ST_RDATA;
          shreg <= rd_data;
          sda_drive <= !rd_data[7];
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
  assign SERIAL_DATA_OUT_PIN_OE = sda_drive;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  wire wr_mask = wr_strobe && (reg_ptr == REG_INT_MASK);
  wire wr_pb = wr_strobe && (reg_ptr == REG_PORT_RESET_PUSHBUTTON);
  always_ff @(posedge MCLK or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      int_mask <= MASK_RST_LOW;
      pb_port <= 4'h0;
      pb_int_clr <= 1'b0;
    end
    else
    begin
      if (load_init)
        int_mask <= auto_s3 ? MASK_RST_HIGH : MASK_RST_LOW;
      else if (wr_mask)
        int_mask <= shreg;
      pb_port <= wr_pb ? shreg[3:0] : 4'h0;
      pb_int_clr <= wr_pb && (shreg[PB_INT_CLR_LO] || shreg[PB_INT_CLR_HI]);
    end
  end
  // ------------------------------------------------------------
  // ports
  // ------------------------------------------------------------
  logic [3:0] icut_p;
  logic [3:0] start_p;
  logic [3:0] pg_p;
  logic [3:0] port_shut;
  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1)
    begin : g_port
      pqc_glitch_filter u_shdn (
        .clk(MCLK),
        .rst_b(core_rst_b),
        .din(PORT_SHUTDOWN_N[g]),
        .dout(shut_f[g])
      );
      assign port_shut[g] = !shut_f[g] || pb_port[g];
      always_ff @(posedge MCLK or negedge core_rst_b)
      begin
        if (!core_rst_b)
          port_en[g] <= 1'b0;
        else if (port_shut[g])
          port_en[g] <= 1'b0;
        else
          port_en[g] <= auto_lvl;
      end
      pqc_port u_port (
        .clk(MCLK),
        .rst_b(core_rst_b),
        .shut(port_shut[g]),
        .enable(port_en[g]),
        .over_cut(oc_s3[g]),
        .out_low(ol_s3[g]),
        .ac_en(AC_DISCONNECT_ENABLE[g]),
        .osc(OSCILLATOR_INPUT),
        .gate_on(SWITCH_GATE_DRIVE[g]),
        .pgood(pg_p[g]),
        .icut_ev(icut_p[g]),
        .start_ev(start_p[g]),
        .sense_drive(PORT_SENSE_PIN[g])
      );
    end
  endgenerate
  // ------------------------------------------------------------
  // event latches and interrupt
  // ------------------------------------------------------------
  logic [7:0] int_src;
  logic int_low;
  assign int_src = (icut_lat != 4'h0 ? 8'h01 << EV_ICUT : 8'h00) |
    (start_lat != 4'h0 ? 8'h01 << EV_START : 8'h00) |
    (pg_lat != 4'h0 ? 8'h01 << EV_PGOOD : 8'h00);
  always_ff @(posedge MCLK or negedge core_rst_b)
  begin
    if (!core_rst_b)
    begin
      icut_lat <= 4'h0;
      start_lat <= 4'h0;
      pg_lat <= 4'h0;
      int_low <= 1'b0;
    end
    else
    begin
      icut_lat <= (pb_int_clr ? 4'h0 : icut_lat) | icut_p;
      start_lat <= (pb_int_clr ? 4'h0 : start_lat) | start_p;
      pg_lat <= (pb_int_clr ? 4'h0 : pg_lat) | pg_p;
      if (!busy)
        int_low <= (int_src & int_mask) != 8'h00;
    end
  end
  assign INT_OE = int_low;
endmodule : pqc_top

// >>> sim/pqc_host_model.sv
// pqc_host_model: serial bus master driving clock and data
// assumes the bench joins both data pins as one wire with pull-up
`timescale 1ns/1ps
module pqc_host_model
  import pqc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = {SLAVE_ADDR_HI, 4'ha}
)
(
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_oe
);
  // ------------------------------------------
  // bus primitives, clock idles high
  // ------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end

  task automatic hc(input int n);
    repeat (n) @(negedge mclk);
  endtask : hc

  task automatic bit_c(input logic b, output logic r);
    hc(1);
    sda_oe = ~b;
    hc(4);
    scl = 1'b1;
    hc(3);
    r = sda;
    scl = 1'b0;
  endtask : bit_c

  task automatic start_c();
    hc(4);
    sda_oe = 1'b1;
    hc(4);
    scl = 1'b0;
  endtask : start_c

  task automatic stop_c();
    hc(1);
    sda_oe = 1'b1;
    hc(4);
    scl = 1'b1;
    hc(4);
    sda_oe = 1'b0;
    hc(8);
  endtask : stop_c

  task automatic xb(input logic [7:0] d, output logic [7:0] q, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_c(d[i], r);
      q[i] = r;
    end
    bit_c(1'b1, r);
    a = ~r;
  endtask : xb

  // ------------------------------------------
  // register transfers
  // ------------------------------------------
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic a0, a1, a2;
    start_c();
    xb({DEV_ADDR, 1'b0}, x, a0);
    xb(p, x, a1);
    xb(d, x, a2);
    stop_c();
    ok = a0 & a1 & a2;
  endtask : wr

  task automatic rd(input logic [7:0] p, output logic [7:0] q, output logic ok);
    logic [7:0] x;
    logic a0, a1, a2, a3;
    start_c();
    xb({DEV_ADDR, 1'b0}, x, a0);
    xb(p, x, a1);
    stop_c();
    start_c();
    xb({DEV_ADDR, 1'b1}, x, a2);
    xb(8'hff, q, a3);
    stop_c();
    ok = a0 & a1 & a2;
  endtask : rd

  task automatic probe(input logic [6:0] ad, output logic ok);
    logic [7:0] x;
    start_c();
    xb({ad, 1'b0}, x, ok);
    stop_c();
  endtask : probe
endmodule : pqc_host_model

// >>> sim/pqc_top_properties.sv
// pqc_top_properties: concurrent checks on the top-level pins
// assumes bound into pqc_top, data wire fed back on the data input
`timescale 1ns/1ps
module pqc_top_properties
  import pqc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic SCL,
  input wire logic SERIAL_DATA_IN_PIN,
  input wire logic SERIAL_DATA_OUT_PIN_OE,
  input wire logic INT_OE,
  input wire logic [3:0] SLAVE_ADDRESS_SELECT_PIN,
  input wire logic [3:0] PORT_SHUTDOWN_N,
  input wire logic AUTO_MODE,
  input wire logic [3:0] OVERCURRENT_THRESHOLD,
  input wire logic [3:0] PORT_VOLTAGE_MONITOR,
  input wire logic [3:0] AC_DISCONNECT_ENABLE,
  input wire logic OSCILLATOR_INPUT,
  input wire logic SUPPLY_UNDERVOLTAGE_LOCKOUT,
  input wire logic [3:0] SWITCH_GATE_DRIVE,
  input wire logic [3:0] PORT_SENSE_PIN
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // ------------------------------------------
  // helper counters and bus activity
  // ------------------------------------------
  logic [5:0] rst_cnt = 6'h00;
  logic [5:0] sd_cnt [4];
  logic [15:0] oc_cnt [4];
  logic scl_q;
  logic sda_q;
  logic busy;
  logic [7:0] busy_sh;

  always_ff @(posedge MCLK)
  begin
    rst_cnt <= RST_B ? 6'h00 : rst_cnt + {5'h00, ~&rst_cnt};
    for (int i = 0; i < 4; i++)
    begin
      sd_cnt[i] <= PORT_SHUTDOWN_N[i] ? 6'h00 : sd_cnt[i] + {5'h00, ~&sd_cnt[i]};
      oc_cnt[i] <= (OVERCURRENT_THRESHOLD[i] && SWITCH_GATE_DRIVE[i]) ? oc_cnt[i] + 16'h0001 : 16'h0000;
    end
  end

  always_ff @(posedge MCLK)
  begin
    scl_q <= SCL;
    sda_q <= SERIAL_DATA_IN_PIN;
    busy_sh <= {busy_sh[6:0], busy};
    if (!RST_B || (SCL && scl_q && !sda_q && SERIAL_DATA_IN_PIN))
      busy <= 1'b0;
    else if (SCL && scl_q && sda_q && !SERIAL_DATA_IN_PIN)
      busy <= 1'b1;
  end

  // ------------------------------------------
  // properties
  // ------------------------------------------
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    rst_cnt > 6'd28 |-> (SWITCH_GATE_DRIVE == 4'h0 && !INT_OE && !SERIAL_DATA_OUT_PIN_OE))
    else $error("outputs active during reset");
  AST_RESET_GLITCH: assert property (disable iff (1'b0)
    (!RST_B && rst_cnt < 6'd15 && SWITCH_GATE_DRIVE != 4'h0) |=> SWITCH_GATE_DRIVE != 4'h0)
    else $error("short reset low dropped the ports");
  AST_SENSE_GATED: assert property (
    PORT_SENSE_PIN == (SWITCH_GATE_DRIVE & AC_DISCONNECT_ENABLE & {4{OSCILLATOR_INPUT}}))
    else $error("sense pin drive mismatch");
  AST_INT_BUS_IDLE: assert property (
    busy && busy_sh[7] |-> $stable(INT_OE))
    else $error("interrupt changed inside a transaction");

  for (genvar g = 0; g < NPORT; g++)
  begin : g_port
    AST_SHDN_OFF: assert property (
      sd_cnt[g] > 6'd30 |-> !SWITCH_GATE_DRIVE[g])
      else $error("port on under long shutdown");
    AST_SHDN_GLITCH: assert property (
      (sd_cnt[g] != 6'h00 && sd_cnt[g] < 6'd15 && SWITCH_GATE_DRIVE[g] && !OVERCURRENT_THRESHOLD[g])
      |=> SWITCH_GATE_DRIVE[g])
      else $error("short shutdown low dropped the port");
    AST_FAULT_EXPIRE: assert property (
      oc_cnt[g] <= (FAULT_TIME_CYC + 16'h0010))
      else $error("port on after fault time");
    AST_FAULT_COUNT: assert property (
      (SWITCH_GATE_DRIVE[g] && oc_cnt[g] != 16'h0000 && oc_cnt[g] < 16'h0700 && PORT_SHUTDOWN_N[g])
      |=> SWITCH_GATE_DRIVE[g])
      else $error("port off before fault time");
  end
endmodule : pqc_top_properties

bind pqc_top pqc_top_properties chk_u (.MCLK(MCLK), .RST_B(RST_B), .SCL(SCL),
  .SERIAL_DATA_IN_PIN(SERIAL_DATA_IN_PIN), .SERIAL_DATA_OUT_PIN_OE(SERIAL_DATA_OUT_PIN_OE),
  .INT_OE(INT_OE), .SLAVE_ADDRESS_SELECT_PIN(SLAVE_ADDRESS_SELECT_PIN), .PORT_SHUTDOWN_N(PORT_SHUTDOWN_N),
  .AUTO_MODE(AUTO_MODE), .OVERCURRENT_THRESHOLD(OVERCURRENT_THRESHOLD), .PORT_VOLTAGE_MONITOR(PORT_VOLTAGE_MONITOR),
  .AC_DISCONNECT_ENABLE(AC_DISCONNECT_ENABLE), .OSCILLATOR_INPUT(OSCILLATOR_INPUT),
  .SUPPLY_UNDERVOLTAGE_LOCKOUT(SUPPLY_UNDERVOLTAGE_LOCKOUT), .SWITCH_GATE_DRIVE(SWITCH_GATE_DRIVE),
  .PORT_SENSE_PIN(PORT_SENSE_PIN));

// >>> sim/tb_poe_quad_port_control_pins.sv
// tb_poe_quad_port_control_pins: self-checking bench for pqc_top
// assumes pqc_host_model as bus master and the bound property checker
`timescale 1ns/1ps
module tb_poe_quad_port_control_pins
  import pqc_pkg::*;
;
  // ------------------------------------------
  // pins and wiring
  // ------------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic auto_mode = 1'b0;
  logic osc = 1'b0;
  logic [3:0] shdn_n = 4'hf;
  logic [3:0] oc = 4'h0;
  logic [3:0] acen = 4'h5;
  logic [3:0] vmon = 4'h0;
  logic supply_undervoltage_lockout = 1'b1;
  logic scl, host_oe, dut_oe, int_oe, ok;
  logic [3:0] gate;
  logic [7:0] q, q2;
  int errors = 0;
  int n_compared = 0;
  wire sda = ~(host_oe | dut_oe);

  always #25 mclk = ~mclk;
  always #800 osc = ~osc;

  pqc_top dut_u (.MCLK(mclk), .RST_B(rst_b), .SCL(scl), .SERIAL_DATA_IN_PIN(sda),
    .SERIAL_DATA_OUT_PIN_OE(dut_oe), .INT_OE(int_oe), .SLAVE_ADDRESS_SELECT_PIN(4'ha),
    .PORT_SHUTDOWN_N(shdn_n), .AUTO_MODE(auto_mode), .OVERCURRENT_THRESHOLD(oc),
    .PORT_VOLTAGE_MONITOR(vmon), .AC_DISCONNECT_ENABLE(acen), .OSCILLATOR_INPUT(osc),
    .SUPPLY_UNDERVOLTAGE_LOCKOUT(supply_undervoltage_lockout), .SWITCH_GATE_DRIVE(gate), .PORT_SENSE_PIN());
  pqc_host_model host_u (.mclk(mclk), .sda(sda), .scl(scl), .sda_oe(host_oe));

  // ------------------------------------------
  // shared tasks
  // ------------------------------------------
  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic rreg(input logic [7:0] p, input logic [7:0] exp, input logic [7:0] msk);
    host_u.rd(p, q, ok);
    chk({7'h00, ok}, 8'h01, "read ack");
    chk(q & msk, exp, "read data");
  endtask : rreg

  task automatic wreg(input logic [7:0] p, input logic [7:0] d);
    host_u.wr(p, d, ok);
    chk({7'h00, ok}, 8'h01, "write ack");
  endtask : wreg

  task automatic wgate(input logic [3:0] m, input logic [3:0] v, input int lim);
    for (int k = 0; k < lim && (gate & m) !== v; k++)
      cyc(1);
    chk({4'h0, gate & m}, {4'h0, v}, "gate wait");
    if ((gate & m) !== v)
      final_report();
  endtask : wgate

  // ------------------------------------------
  // main sequence
  // ------------------------------------------
  initial
  begin
    cyc(2);
    supply_undervoltage_lockout = 1'b0;
    cyc(28);
    chk({int_oe, dut_oe, 2'b00, gate}, 8'h00, "outputs in reset");
    rst_b = 1'b1;
    cyc(40);
    rreg(REG_INT_MASK, MASK_RST_LOW, 8'hff);
    rreg(REG_PIN_STATUS, 8'h00, 8'h01);
    host_u.probe({3'h3, 4'ha}, ok);
    chk({7'h00, ok}, 8'h00, "foreign address acked");
    auto_mode = 1'b1;
    rreg(REG_PIN_STATUS, 8'h01, 8'h01);
    $display("test registers and address done");
    rst_b = 1'b0;
    cyc(30);
    chk({int_oe, dut_oe, 2'b00, gate}, 8'h00, "outputs in reset");
    rst_b = 1'b1;
    wgate(4'hf, 4'hf, 20000);
    rreg(REG_INT_MASK, MASK_RST_HIGH, 8'hff);
    wreg(REG_INT_MASK, 8'h00);
    rreg(REG_INT_MASK, 8'h00, 8'hff);
    supply_undervoltage_lockout = 1'b1;
    cyc(10);
    supply_undervoltage_lockout = 1'b0;
    cyc(10);
    rreg(REG_INT_MASK, MASK_RST_HIGH, 8'hff);
    wreg(REG_INT_MASK, 8'h00);
    rst_b = 1'b0;
    cyc(10);
    rst_b = 1'b1;
    cyc(40);
    rreg(REG_INT_MASK, 8'h00, 8'hff);
    chk({4'h0, gate}, 8'h0f, "gates after reset glitch");
    $display("test auto mode and reset filter done");
    shdn_n = 4'he;
    cyc(10);
    shdn_n = 4'hf;
    cyc(30);
    chk({4'h0, gate}, 8'h0f, "gates after shutdown glitch");
    shdn_n = 4'he;
    cyc(40);
    chk({4'h0, gate}, 8'h0e, "gates under shutdown");
    shdn_n = 4'hf;
    wgate(4'h2, 4'h2, 60);
    fork
      wreg(REG_PORT_RESET_PUSHBUTTON, 8'h02);
      wgate(4'h2, 4'h0, 400);
    join
    vmon = 4'h1;
    rreg(REG_POWER_EVENT, 8'h1f, 8'hff);
    vmon = 4'h0;
    $display("test shutdown done");
    for (int j = 0; j < 2; j++)
    begin
      oc = 4'h4 << j;
      wgate(4'h4 << j, 4'h0, 2400);
      oc = 4'h0;
      cyc(20);
      chk({7'h00, int_oe}, 8'h00, "masked interrupt");
      wreg(REG_INT_MASK, 8'h60);
      cyc(10);
      chk({7'h00, int_oe}, 8'h01, "enabled interrupt");
      host_u.rd(REG_FAULT_EVENT, q, ok);
      host_u.rd(REG_START_EVENT, q2, ok);
      chk((q | q2) & (8'h04 << j), 8'h04 << j, "fault recorded");
      wreg(REG_PORT_RESET_PUSHBUTTON, 8'h40 << j);
      cyc(10);
      chk({7'h00, int_oe}, 8'h00, "interrupt release");
      wreg(REG_INT_MASK, 8'h00);
    end
    $display("test faults and interrupt done");
    final_report();
  end
endmodule : tb_poe_quad_port_control_pins
